// *** rtl/hub_rst_defines.svh ***
// Constants for the hub reset and link power sequencer
// Overview of operation
// R01: After a power-delivery altmode failure, the host may enumerate the Billboard function.
// R02: Billboard appears only after the PD controller's dedicated configuration command.
// R03: Billboard descriptors come only from OTP; configuration writes to them are refused.
// R04: Three link power states are kept: on, sleep and suspend.
// R05: Suspend entry takes about 3 ms; resume to on about 2 ms.
// R06: Sleep entry finishes under 10 us; sleep exit finishes under 50 us.
// R07: Reset sources are power-on detect, external reset pin and upstream bus reset.
// R08: Power-on holds internal reset for a timed interval before release.
// R09: While the external reset pin is low, the chip sits in standby.
// R10: External reset disables the PHY and floats the differential pairs.
// R11: External reset aborts transactions and returns all state to defaults.
// R12: External reset stops the crystal oscillator and PLL until release.
// R13: Upstream bus reset clears address, unconfigures and leaves suspend.
// R14: Upstream bus reset is never forwarded to downstream ports.
// R15: Board supervisor may hold reset low through power-up instead of meeting rise time.
// R16: Reset pin active low; internal release is synchronous to the restarted clock.
`ifndef HUB_RST_DEFINES_SVH
`define HUB_RST_DEFINES_SVH

`define CLK_PERIOD_NS 5
`define ADDR_W 7
`define CFG_W 8
`define ADDR_RST 7'h00
`define CFG_RST 8'h00
`define TMR_W 20

`define L2_ENTRY_NS 3000000
`define L2_EXIT_NS 2000000
`define L1_ENTRY_NS 10000
`define L1_EXIT_NS 50000
`define POR_HOLD_NS 100000
`define OSC_START_NS 1000

`define L2_ENTRY_CYC (`L2_ENTRY_NS / `CLK_PERIOD_NS)
`define L2_EXIT_CYC (`L2_EXIT_NS / `CLK_PERIOD_NS)
`define L1_ENTRY_CYC ((`L1_ENTRY_NS / `CLK_PERIOD_NS) - 1)
`define L1_EXIT_CYC ((`L1_EXIT_NS / `CLK_PERIOD_NS) - 1)
`define POR_HOLD_CYC (`POR_HOLD_NS / `CLK_PERIOD_NS)
`define OSC_START_CYC (`OSC_START_NS / `CLK_PERIOD_NS)

`define BB_ACTIVATE_CMD 8'ha5
`define BB_DESC_BASE 13'h1c00
`define OTP_AW 13

`endif

// *** rtl/hub_rst_pkg.sv ***
// Types for the hub reset and link power sequencer
`include "hub_rst_defines.svh"
package hub_rst_pkg;
   typedef enum logic [1:0] {
      LINK_L0 = 2'b00,
      LINK_L1 = 2'b01,
      LINK_L2 = 2'b10
   } link_t;

   typedef enum logic [2:0] {
      LPM_L0 = 3'b000,
      LPM_L1_ENTER = 3'b001,
      LPM_L1 = 3'b010,
      LPM_L1_EXIT = 3'b011,
      LPM_L2_ENTER = 3'b100,
      LPM_L2 = 3'b101,
      LPM_L2_EXIT = 3'b110
   } lpm_st_t;

   typedef struct packed {
      logic [`TMR_W-1:0] rst_cnt;
      logic rst_busy;
      lpm_st_t lpm;
      logic [`ADDR_W-1:0] addr;
      logic [`CFG_W-1:0] cfg;
      logic fail;
      logic bb_on;
      logic rd_pend;
      logic [7:0] desc_data;
      logic desc_vld;
      logic refused;
   } hub_st_t;

   typedef struct packed {
      logic [`TMR_W-1:0] cnt;
      logic busy;
      logic done;
   } tmr_st_t;
endpackage

// *** rtl/lpm_timer.sv ***
// Load-and-count-down timer for link power transitions
`timescale 1ns/1ps
`default_nettype none
module lpm_timer #(
   parameter int W = 20
) (
   input wire logic clk,           // 200 MHz clock
   input wire logic srst,          // Synchronous reset
   input wire logic clr,           // Abandon the running count
   input wire logic load,          // Start a count
   input wire logic [W-1:0] val,   // Cycles until done
   output logic busy,              // Count running
   output logic done               // One-cycle pulse at expiry
);
   hub_rst_pkg::tmr_st_t st_r, st_nxt;

   always_comb begin
      st_nxt = st_r;
      st_nxt.done = 1'b0;
      if (clr) begin
         st_nxt.busy = 1'b0;
         st_nxt.cnt = '0;
      end else if (load) begin
         st_nxt.busy = 1'b1;
         st_nxt.cnt = (val == '0) ? W'(1) : val;
      end else if (st_r.busy) begin
         if (st_r.cnt == W'(1)) begin
            st_nxt.busy = 1'b0;
            st_nxt.done = 1'b1;
         end
         st_nxt.cnt = st_r.cnt - W'(1);
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign busy = st_r.busy;
   assign done = st_r.done;
endmodule
`default_nettype wire

// *** rtl/hub_reset_and_link_power.sv ***
// Chip reset sources, link power states and Billboard activation
`timescale 1ns/1ps
`default_nettype none
`include "hub_rst_defines.svh"
module hub_reset_and_link_power #(
   parameter int unsigned L2_ENTRY_CYC = `L2_ENTRY_CYC,
   parameter int unsigned L2_EXIT_CYC = `L2_EXIT_CYC,
   parameter int unsigned L1_EXIT_CYC = `L1_EXIT_CYC,
   parameter int unsigned POR_HOLD_CYC = `POR_HOLD_CYC
) (
   input wire logic clk,                      // 200 MHz clock
   input wire logic srst,                     // Synchronous reset
   input wire logic por_det,                  // Supply below power-on threshold
   input wire logic ext_rst_n,                // External chip reset pin
   input wire logic usb_bus_rst,              // Upstream bus reset seen, pulse
   input wire logic set_addr_stb,             // Host assigns address
   input wire logic [`ADDR_W-1:0] set_addr,   // Address value
   input wire logic set_cfg_stb,              // Host selects configuration
   input wire logic [`CFG_W-1:0] set_cfg,     // Configuration value
   input wire logic lpm_l1_req,               // Accepted sleep request
   input wire logic suspend_req,              // Upstream bus idle, suspend
   input wire logic resume_start,             // Resume signalling begins
   input wire logic l1_wake,                  // Sleep exit request
   input wire logic pd_altmode_fail,          // PD controller reports failure
   input wire logic smb_cmd_stb,              // Configuration command strobe
   input wire logic [7:0] smb_cmd,            // Configuration command code
   input wire logic smb_desc_wr_stb,          // Attempt to write descriptor
   input wire logic bb_desc_rd_stb,           // Descriptor byte request
   input wire logic [9:0] bb_desc_addr,       // Descriptor byte offset
   input wire logic [7:0] otp_rd_data,        // OTP read data
   input wire logic otp_rd_valid,             // OTP read data valid
   output logic core_rst,                     // Internal chip reset
   output logic standby,                      // Low current standby
   output logic phy_en,                       // PHY enable
   output logic dp_hiz,                       // Differential pairs floated
   output logic osc_en,                       // Crystal oscillator run
   output logic pll_en,                       // PLL run
   output logic txn_abort,                    // Kill transactions in flight
   output logic dn_port_rst,                  // Downstream port reset
   output logic [`ADDR_W-1:0] dev_addr,       // Device address
   output logic [`CFG_W-1:0] dev_cfg,         // Current configuration
   output logic configured,                   // Configuration nonzero
   output logic [1:0] link_state,             // Link power state
   output logic lpm_busy,                     // Transition in progress
   output logic bb_fail_seen,                 // Failure latched
   output logic bb_present,                   // Billboard function attached
   output logic otp_rd_stb,                   // OTP read request
   output logic [`OTP_AW-1:0] otp_rd_addr,    // OTP read address
   output logic [7:0] bb_desc_data,           // Descriptor byte
   output logic bb_desc_valid,                // Descriptor byte valid
   output logic smb_refused                   // Descriptor write refused
);
   hub_rst_pkg::hub_st_t st_r, st_nxt;
   logic chip_rst;
   logic tmr_load;
   logic [`TMR_W-1:0] tmr_val;
   logic tmr_busy;
   logic tmr_done;

   // Pin reset or power-on detection force every state back to default
   assign chip_rst = !ext_rst_n || por_det; // [R07] [R11]

   lpm_timer #(.W(`TMR_W)) u_tmr (
      .clk(clk),
      .srst(srst),
      .clr(chip_rst || usb_bus_rst),
      .load(tmr_load),
      .val(tmr_val),
      .busy(tmr_busy),
      .done(tmr_done)
   );

   always_comb begin
      st_nxt = st_r;
      tmr_load = 1'b0;
      tmr_val = '0;
      st_nxt.desc_vld = 1'b0;
      st_nxt.refused = 1'b0;
      if (chip_rst) begin
         st_nxt = '0; // [R11]
         st_nxt.rst_busy = 1'b1;
         // Power-on loads the full hold; pin reset only the clock restart
         st_nxt.rst_cnt = por_det ? `TMR_W'(POR_HOLD_CYC) : `TMR_W'(`OSC_START_CYC); // [R08]
      end else begin
         // Release counted on the running clock after the source goes away
         if (st_r.rst_busy) begin
            if (st_r.rst_cnt <= `TMR_W'(1)) begin
               st_nxt.rst_busy = 1'b0; // [R16] [R08]
               st_nxt.rst_cnt = '0;
            end else begin
               st_nxt.rst_cnt = st_r.rst_cnt - `TMR_W'(1);
            end
         end
         if (set_addr_stb) begin
            st_nxt.addr = set_addr;
         end
         if (set_cfg_stb) begin
            st_nxt.cfg = set_cfg;
         end
         if (pd_altmode_fail) begin
            st_nxt.fail = 1'b1;
         end
         // Billboard only by the dedicated command after a failure
         if (smb_cmd_stb && smb_cmd == `BB_ACTIVATE_CMD && (st_r.fail || pd_altmode_fail)) begin
            st_nxt.bb_on = 1'b1; // [R01] [R02]
         end
         // No write path to descriptors: attempts only flag a refusal
         if (smb_desc_wr_stb) begin
            st_nxt.refused = 1'b1; // [R03]
         end
         if (bb_desc_rd_stb && st_r.bb_on) begin
            st_nxt.rd_pend = 1'b1;
         end
         if (st_r.rd_pend && otp_rd_valid) begin
            st_nxt.rd_pend = 1'b0;
            st_nxt.desc_data = otp_rd_data; // [R03]
            st_nxt.desc_vld = 1'b1;
         end
         unique case (st_r.lpm)
            hub_rst_pkg::LPM_L0: begin
               if (suspend_req) begin
                  st_nxt.lpm = hub_rst_pkg::LPM_L2_ENTER; // [R04]
                  tmr_load = 1'b1;
                  tmr_val = `TMR_W'(L2_ENTRY_CYC); // [R05]
               end else if (lpm_l1_req) begin
                  st_nxt.lpm = hub_rst_pkg::LPM_L1_ENTER; // [R04]
                  tmr_load = 1'b1;
                  // Move lands a cycle after expiry; load one short to stay under
                  tmr_val = `TMR_W'(`L1_ENTRY_CYC - 1); // [R06]
               end
            end
            hub_rst_pkg::LPM_L1_ENTER: begin
               if (tmr_done) begin
                  st_nxt.lpm = hub_rst_pkg::LPM_L1;
               end
            end
            hub_rst_pkg::LPM_L1: begin
               if (l1_wake || resume_start) begin
                  st_nxt.lpm = hub_rst_pkg::LPM_L1_EXIT;
                  tmr_load = 1'b1;
                  tmr_val = `TMR_W'(L1_EXIT_CYC - 1); // [R06]
               end
            end
            hub_rst_pkg::LPM_L1_EXIT: begin
               if (tmr_done) begin
                  st_nxt.lpm = hub_rst_pkg::LPM_L0;
               end
            end
            hub_rst_pkg::LPM_L2_ENTER: begin
               if (tmr_done) begin
                  st_nxt.lpm = hub_rst_pkg::LPM_L2;
               end
            end
            hub_rst_pkg::LPM_L2: begin
               if (resume_start) begin
                  st_nxt.lpm = hub_rst_pkg::LPM_L2_EXIT;
                  tmr_load = 1'b1;
                  tmr_val = `TMR_W'(L2_EXIT_CYC); // [R05]
               end
            end
            hub_rst_pkg::LPM_L2_EXIT: begin
               if (tmr_done) begin
                  st_nxt.lpm = hub_rst_pkg::LPM_L0;
               end
            end
            default: begin
               st_nxt.lpm = hub_rst_pkg::LPM_L0;
            end
         endcase
         // Bus reset wins over any host update or power move this cycle
         if (usb_bus_rst) begin
            st_nxt.addr = `ADDR_RST; // [R13]
            st_nxt.cfg = `CFG_RST; // [R13]
            st_nxt.lpm = hub_rst_pkg::LPM_L0; // [R13]
            tmr_load = 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         st_r <= '0;
         st_r.rst_busy <= 1'b1;
         st_r.rst_cnt <= `TMR_W'(`OSC_START_CYC);
      end else begin
         st_r <= st_nxt;
      end
   end

   // Pin-driven controls follow the pin at once, no clock needed to stop
   assign standby = !ext_rst_n; // [R09]
   assign phy_en = ext_rst_n && !st_r.rst_busy; // [R10]
   assign dp_hiz = !phy_en; // [R10]
   assign osc_en = ext_rst_n; // [R12]
   assign pll_en = ext_rst_n; // [R12]
   assign txn_abort = chip_rst || st_r.rst_busy; // [R11]
   assign core_rst = chip_rst || st_r.rst_busy; // [R08] [R16]
   // Only chip resets reach downstream; the bus reset does not
   assign dn_port_rst = st_r.rst_busy; // [R14]
   assign dev_addr = st_r.addr;
   assign dev_cfg = st_r.cfg;
   assign configured = (st_r.cfg != `CFG_RST);
   always_comb begin
      unique case (st_r.lpm)
         hub_rst_pkg::LPM_L1, hub_rst_pkg::LPM_L1_EXIT: link_state = hub_rst_pkg::LINK_L1;
         hub_rst_pkg::LPM_L2, hub_rst_pkg::LPM_L2_EXIT: link_state = hub_rst_pkg::LINK_L2;
         default: link_state = hub_rst_pkg::LINK_L0;
      endcase
   end
   assign lpm_busy = tmr_busy;
   assign bb_fail_seen = st_r.fail;
   assign bb_present = st_r.bb_on;
   assign otp_rd_stb = st_r.rd_pend;
   assign otp_rd_addr = `BB_DESC_BASE + {3'h0, bb_desc_addr}; // [R03]
   assign bb_desc_data = st_r.desc_data;
   assign bb_desc_valid = st_r.desc_vld;
   assign smb_refused = st_r.refused;

   // Cycles spent in the current power state, for timing checks
   logic [`TMR_W-1:0] dwell_r;
   always_ff @(posedge clk) begin
      if (srst || st_nxt.lpm != st_r.lpm) begin
         dwell_r <= '0;
      end else if (dwell_r != '1) begin
         dwell_r <= dwell_r + `TMR_W'(1);
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   property p_standby;
      !ext_rst_n |-> standby && !phy_en && dp_hiz && core_rst;
   endproperty
   a_standby: assert property (p_standby) else $error("pin reset not in standby"); // [R09] [R10]

   property p_clk_stop;
      !ext_rst_n |-> !osc_en && !pll_en;
   endproperty
   a_clk_stop: assert property (p_clk_stop) else $error("clocks run under reset"); // [R12]

   property p_defaults;
      !ext_rst_n |=> dev_addr == `ADDR_RST && !configured && !bb_present && !bb_fail_seen
         && link_state == hub_rst_pkg::LINK_L0;
   endproperty
   a_defaults: assert property (p_defaults) else $error("state kept over reset"); // [R11]

   property p_por_hold;
      $fell(por_det) && ext_rst_n |-> core_rst [*8];
   endproperty
   a_por_hold: assert property (p_por_hold) else $error("power-on hold too short"); // [R08]

   property p_sync_release;
      $rose(ext_rst_n) |-> core_rst ##1 core_rst;
   endproperty
   a_sync_release: assert property (p_sync_release) else $error("release not clocked"); // [R16]

   property p_bus_rst;
      usb_bus_rst && !chip_rst |=> dev_addr == `ADDR_RST && !configured
         && link_state == hub_rst_pkg::LINK_L0 && !dn_port_rst;
   endproperty
   a_bus_rst: assert property (p_bus_rst) else $error("bus reset mishandled"); // [R13] [R14]

   property p_bb_cmd;
      $rose(bb_present) |-> $past(smb_cmd_stb) && $past(smb_cmd) == `BB_ACTIVATE_CMD && bb_fail_seen;
   endproperty
   a_bb_cmd: assert property (p_bb_cmd) else $error("billboard without command"); // [R01] [R02]

   property p_desc_otp;
      bb_desc_valid |-> $past(otp_rd_valid) && bb_desc_data == $past(otp_rd_data);
   endproperty
   a_desc_otp: assert property (p_desc_otp) else $error("descriptor not from otp"); // [R03]

   property p_desc_wr;
      smb_desc_wr_stb && !chip_rst |=> smb_refused;
   endproperty
   a_desc_wr: assert property (p_desc_wr) else $error("descriptor write accepted"); // [R03]

   property p_l1_entry;
      st_r.lpm == hub_rst_pkg::LPM_L1_ENTER |-> dwell_r < `TMR_W'(`L1_ENTRY_CYC);
   endproperty
   a_l1_entry: assert property (p_l1_entry) else $error("sleep entry too slow"); // [R06]

   property p_l1_exit;
      st_r.lpm == hub_rst_pkg::LPM_L1_EXIT |-> dwell_r < `TMR_W'(L1_EXIT_CYC);
   endproperty
   a_l1_exit: assert property (p_l1_exit) else $error("sleep exit too slow"); // [R06]

   property p_l2_time;
      st_r.lpm == hub_rst_pkg::LPM_L2_ENTER && tmr_done |-> dwell_r == `TMR_W'(L2_ENTRY_CYC);
   endproperty
   a_l2_time: assert property (p_l2_time) else $error("suspend entry time wrong"); // [R05]

   c_l2_round: cover property (link_state == hub_rst_pkg::LINK_L2 ##1 resume_start);
   c_l1_round: cover property (st_r.lpm == hub_rst_pkg::LPM_L1_EXIT && tmr_done);
   c_bb_on: cover property ($rose(bb_present));
   c_bus_rst_l2: cover property (usb_bus_rst && link_state == hub_rst_pkg::LINK_L2);
endmodule
`default_nettype wire

// *** verification/otp_store_model.sv ***
// Behavioural OTP store answering descriptor byte reads
`timescale 1ns/1ps
`default_nettype none
module otp_store_model (
   input wire logic clk,              // 200 MHz clock
   input wire logic srst,             // Synchronous reset
   input wire logic rd_stb,           // Read request, held until answered
   input wire logic [12:0] rd_addr,   // Byte address
   input wire logic [3:0] delay,      // Extra wait cycles before the answer
   output logic [7:0] rd_data,        // Byte, garbage outside the valid cycle
   output logic rd_valid              // One-cycle answer strobe
);
   logic [3:0] cnt_r;
   logic cool_r;

   // Stored byte pattern; addresses with the same low byte hold the same value (low byte XOR 8'h3c)
   function automatic logic [7:0] otp_byte(input logic [12:0] a);
      return a[7:0] ^ 8'h3c;
   endfunction

   always_ff @(posedge clk) begin
      rd_valid <= 1'b0;
      // Data does not hold outside the answer cycle
      rd_data <= ~rd_data;
      if (srst) begin
         cnt_r <= 4'h0;
         cool_r <= 1'b0;
         rd_data <= 8'h00;
      end else if (cool_r) begin
         // Requester still shows the old strobe for one edge after the answer
         cool_r <= 1'b0;
      end else if (rd_stb) begin
         if (cnt_r == delay) begin
            rd_valid <= 1'b1;
            rd_data <= otp_byte(rd_addr);
            cnt_r <= 4'h0;
            cool_r <= 1'b1;
         end else begin
            cnt_r <= cnt_r + 4'h1;
         end
      end
   end
endmodule
`default_nettype wire

// *** verification/hub_reset_and_link_power_tb.sv ***
// Self-checking bench for the hub reset and link power block
`timescale 1ns/1ps
`default_nettype none
`include "hub_rst_defines.svh"
module hub_reset_and_link_power_tb;
   localparam int unsigned LX = 20;
   localparam int unsigned PH = 16;
   localparam int unsigned L1E = `L1_ENTRY_CYC;
   typedef struct {int k; logic [1:0] st; int lo; int hi;} row_t;
   logic clk, srst, por_det, ext_rst_n, usb_bus_rst, set_addr_stb, set_cfg_stb;
   logic lpm_l1_req, suspend_req, resume_start, l1_wake, pd_altmode_fail, smb_cmd_stb;
   logic smb_desc_wr_stb, bb_desc_rd_stb, otp_rd_valid;
   logic [`ADDR_W-1:0] set_addr, dev_addr;
   logic [`CFG_W-1:0] set_cfg, dev_cfg;
   logic [7:0] smb_cmd, otp_rd_data, bb_desc_data;
   logic [9:0] bb_desc_addr;
   logic [3:0] otp_delay;
   logic core_rst, standby, phy_en, dp_hiz, osc_en, pll_en, txn_abort, dn_port_rst;
   logic configured, lpm_busy, bb_fail_seen, bb_present, otp_rd_stb;
   logic bb_desc_valid, smb_refused;
   logic [1:0] link_state;
   logic [`OTP_AW-1:0] otp_rd_addr;
   int bad_count, n_tests, n;
   row_t rows [6] = '{'{0, hub_rst_pkg::LINK_L1, 1, L1E}, '{1, hub_rst_pkg::LINK_L0, LX, LX+1},
      '{0, hub_rst_pkg::LINK_L1, 1, L1E}, '{2, hub_rst_pkg::LINK_L0, LX, LX+1},
      '{3, hub_rst_pkg::LINK_L2, LX, LX+1}, '{2, hub_rst_pkg::LINK_L0, LX, LX+1}};

   hub_reset_and_link_power #(.L2_ENTRY_CYC(LX), .L2_EXIT_CYC(LX), .L1_EXIT_CYC(LX),
      .POR_HOLD_CYC(PH)) u_hub_reset_and_link_power (.clk, .srst, .por_det, .ext_rst_n,
      .usb_bus_rst, .set_addr_stb, .set_addr, .set_cfg_stb, .set_cfg, .lpm_l1_req,
      .suspend_req, .resume_start, .l1_wake, .pd_altmode_fail, .smb_cmd_stb, .smb_cmd,
      .smb_desc_wr_stb, .bb_desc_rd_stb, .bb_desc_addr, .otp_rd_data, .otp_rd_valid,
      .core_rst, .standby, .phy_en, .dp_hiz, .osc_en, .pll_en, .txn_abort, .dn_port_rst,
      .dev_addr, .dev_cfg, .configured, .link_state, .lpm_busy, .bb_fail_seen, .bb_present,
      .otp_rd_stb, .otp_rd_addr, .bb_desc_data, .bb_desc_valid, .smb_refused);

   otp_store_model u_otp_store_model (.clk, .srst, .rd_stb(otp_rd_stb), .rd_addr(otp_rd_addr),
      .delay(otp_delay), .rd_data(otp_rd_data), .rd_valid(otp_rd_valid));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   task automatic finish_test();
      $display("tests %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic drive(input int k, input logic v);
      case (k)
         0: lpm_l1_req = v;
         1: l1_wake = v;
         2: resume_start = v;
         3: suspend_req = v;
         4: usb_bus_rst = v;
         5: set_addr_stb = v;
         6: set_cfg_stb = v;
         7: pd_altmode_fail = v;
         8: smb_cmd_stb = v;
         9: smb_desc_wr_stb = v;
         default: bb_desc_rd_stb = v;
      endcase
   endtask

   // One-cycle strobe; returns at the falling edge after the taking edge
   task automatic pulse(input int k);
      @(negedge clk);
      drive(k, 1'b1);
      @(negedge clk);
      drive(k, 1'b0);
   endtask

   task automatic wait_link(input logic [1:0] st);
      n = 0;
      while (link_state !== st && n < 3000) begin
         @(negedge clk);
         n++;
      end
   endtask

   task automatic wait_rst();
      n = 0;
      while (core_rst !== 1'b0 && n < 500) begin
         @(negedge clk);
         n++;
      end
   endtask

   task automatic rd_desc(input logic [9:0] off, input logic [3:0] dly);
      logic [12:0] a;
      a = `BB_DESC_BASE + {3'h0, off};
      otp_delay = dly;
      bb_desc_addr = off;
      pulse(10);
      chk(otp_rd_addr, a, "otp address");
      n = 0;
      while (bb_desc_valid !== 1'b1 && n < 40) begin
         @(negedge clk);
         n++;
      end
      chk(bb_desc_data, a[7:0] ^ 8'h3c, "descriptor byte");
      @(negedge clk);
      chk(otp_rd_stb, 1'b0, "otp request released");
   endtask

   initial begin
      #200000;
      bad_count++;
      $display("unexpected at %0t: watchdog expired", $time);
      finish_test();
   end

   initial begin
      bad_count = 0;
      n_tests = 0;
      {srst, ext_rst_n} = 2'b11;
      {por_det, usb_bus_rst, set_addr_stb, set_cfg_stb, lpm_l1_req, suspend_req} = '0;
      {resume_start, l1_wake, pd_altmode_fail, smb_cmd_stb, smb_desc_wr_stb} = '0;
      {bb_desc_rd_stb, set_addr, set_cfg, smb_cmd, bb_desc_addr} = '0;
      otp_delay = 4'h0;
      repeat (3) @(negedge clk);
      srst = 1'b0;
      wait_rst();
      chk(n >= 195 && n <= 202, 1, "reset release time");
      chk(link_state, hub_rst_pkg::LINK_L0, "link after reset");
      chk({dev_addr, bb_present, dn_port_rst, phy_en}, 10'h001, "state after reset");
      $display("test reset done");

      foreach (rows[i]) begin
         pulse(rows[i].k);
         wait_link(rows[i].st);
         chk(n >= rows[i].lo && n <= rows[i].hi, 1, "link transition time");
      end
      $display("test link states done");

      set_addr = 7'h2a;
      set_cfg = 8'h03;
      pulse(5);
      pulse(6);
      chk({dev_addr, configured}, {7'h2a, 1'b1}, "address and configuration");
      pulse(3);
      wait_link(hub_rst_pkg::LINK_L2);
      pulse(0);
      repeat (30) @(negedge clk);
      chk(link_state, hub_rst_pkg::LINK_L2, "sleep request in suspend");
      pulse(4);
      chk({dev_addr, dev_cfg, configured}, 16'h0, "bus reset clears");
      chk(link_state, hub_rst_pkg::LINK_L0, "bus reset resumes");
      chk(dn_port_rst, 1'b0, "bus reset kept upstream");
      $display("test bus reset done");

      smb_cmd = `BB_ACTIVATE_CMD;
      pulse(8);
      chk(bb_present, 1'b0, "command without failure");
      pulse(7);
      chk(bb_fail_seen, 1'b1, "failure latched");
      smb_cmd = 8'h5a;
      pulse(8);
      chk(bb_present, 1'b0, "wrong command code");
      smb_cmd = `BB_ACTIVATE_CMD;
      pulse(8);
      chk(bb_present, 1'b1, "function attached");
      rd_desc(10'h000, 4'h0);
      rd_desc(10'h155, 4'h3);
      rd_desc(10'h3ff, 4'h7);
      pulse(9);
      chk(smb_refused, 1'b1, "descriptor write refused");
      rd_desc(10'h000, 4'h1);
      $display("test billboard done");

      set_addr = 7'h11;
      pulse(5);
      pulse(0);
      repeat (5) @(negedge clk);
      ext_rst_n = 1'b0;
      #1;
      chk({standby, phy_en, dp_hiz}, 3'b101, "pin reset standby and phy");
      chk({osc_en, pll_en}, 2'b00, "clocks stopped");
      chk({core_rst, txn_abort}, 2'b11, "transactions aborted");
      @(negedge clk);
      chk({dev_addr, bb_present, bb_fail_seen, lpm_busy}, 10'h0, "state cleared");
      repeat (5) @(negedge clk);
      ext_rst_n = 1'b1;
      wait_rst();
      chk(n >= 199 && n <= 202, 1, "pin release time");
      chk({link_state, lpm_busy, phy_en}, 4'h1, "no stale transition");
      $display("test pin reset done");

      por_det = 1'b1;
      repeat (3) @(negedge clk);
      chk(core_rst, 1'b1, "power-on reset held");
      por_det = 1'b0;
      wait_rst();
      chk(n >= PH - 1 && n <= PH + 2, 1, "power-on hold time");
      $display("test power-on done");

      // Board supervisor keeps the pin low until the supply has settled
      ext_rst_n = 1'b0;
      por_det = 1'b1;
      repeat (3) @(negedge clk);
      por_det = 1'b0;
      repeat (3) @(negedge clk);
      chk(core_rst, 1'b1, "supervisor holds pin through power-up");
      ext_rst_n = 1'b1;
      wait_rst();
      chk(n >= 199 && n <= 202, 1, "release follows the pin");
      $display("test supervisor hold done");
      finish_test();
   end
endmodule
`default_nettype wire
